//--- rtl/rsr_reset_recorder.sv
/*
  Reset source recorder: times the internal reset
  for each request and keeps sticky cause flags
  readable over APB.
  Assumes nrst is the power-on reset; the internal reset it drives does
  not reset this block, so the flags survive the resets they record.
*/
// The APB interface to the registers and the register offsets are this design's own decisions.
// Overview of operation
// RQ1 - Independent watchdog underflow: reset or NMI, flag
// RQ2 - Windowed watchdog overflow: reset or NMI, flag
// RQ3 - Independent watchdog reset self-releases
// RQ4 - Windowed watchdog reset self-releases
// RQ5 - Three supply monitors, interrupt or reset each
// RQ6 - Each monitor threshold selects one of three
// RQ7 - Release only after supply settles
// RQ8 - Monitors off after power-on; option word enables
// RQ9 - Monitor reset sets its own cause flag
// RQ10 - Core reset request bit makes software reset
// RQ11 - Software reset held fixed time then released
// RQ12 - Fault resets need no enabling
// RQ13 - Cold/warm flag cleared only by power-on
// RQ14 - Writing one sets cold/warm flag; zero ignored
// RQ15 - Even parity per byte, checked on read
// RQ16 - ECC corrects one, detects two bit errors
// RQ17 - Parity error can trigger dedicated reset
// RQ18 - Power-on sets its flag; pin reset clears
// RQ19 - Software reset sets its own cause flag
// RQ20 - Cause flags survive the reset they record
`default_nettype none
module rsr_reset_recorder
  import rsr_pkg::*;
(
  input wire logic core_clk, // System clock
  input wire logic nrst, // Power-on reset, active low
  input wire logic clk_en, // Freezes state when low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic indep_watchdog_underflow, // Watchdog underflow pulse
  input wire logic windowed_watchdog_overflow, // Watchdog overflow pulse
  input wire logic [2:0] supply_below, // Monitor comparators, 1 = low
  output logic [5:0] supply_monitor_level, // Two-bit level per monitor
  input wire logic [11:0] option_setting_word, // Monitor setup word
  input wire logic system_reset_request_bit, // Core reset request
  input wire logic [2:0] periph_fault, // Bus/stack fault requests
  input wire logic external_reset_pin_n, // Pin reset, active low
  input wire logic sram_rd_par, // Parity area read strobe
  input wire logic sram_rd_ecc, // ECC area read strobe
  input wire logic [31:0] sram_rd_data, // SRAM read word
  input wire logic [3:0] sram_rd_par_bits, // Stored parity
  input wire logic [6:0] sram_rd_chk, // Stored ECC bits
  output logic [31:0] sram_cor_data, // Corrected ECC word
  output logic internal_reset, // Internal reset, active high
  output logic nmi_req, // Non-maskable interrupt pulse
  output logic [2:0] supply_irq // Monitor interrupt pulses
);
  logic [31:0] cfg_r;
  logic [11:0] mon_r;
  logic [3:0] stat0_r;
  logic [5:0] stat1_r;
  logic cws_r;
  logic [2:0] err_r;
  logic swreq_r;
  rsr_state_t state_r;
  logic [RSR_CNT_W-1:0] cnt_r;
  logic [RSR_CNT_W-1:0] hold_nxt;
  logic mon_hold_r;
  logic [2:0] below_r;
  logic par_err, ecc_single, ecc_double;
  logic wr, rd;
  logic iwd_rst, wwd_rst, par_rst, ecc_rst, flt_rst;
  logic [2:0] mon_rst, mon_irq;
  logic start;
  logic [31:0] rdata;

  // Monitor field fetch used for each of the three monitors
  function automatic logic mon_bit(input logic [11:0] m, input int n,
                                   input int f);
    return m[n*RSR_MON_STRIDE + f];
  endfunction

  assign wr = psel && penable && pwrite && pready;
  assign rd = psel && !penable && !pwrite;

  // Request decode
  assign iwd_rst = indep_watchdog_underflow &&
                   cfg_r[RSR_CFG_IWD_RST]; // RQ1
  assign wwd_rst = windowed_watchdog_overflow &&
                   cfg_r[RSR_CFG_WWD_RST]; // RQ2
  assign par_rst = par_err && cfg_r[RSR_CFG_PAR_RST]; // RQ17
  assign ecc_rst = ecc_double && cfg_r[RSR_CFG_ECC_RST];
  assign flt_rst = |periph_fault; // RQ12
  always_comb begin
    for (int n = 0; n < 3; n++) begin
      // Disabled monitors stay silent
      mon_rst[n] = supply_below[n] && !below_r[n] &&
                   mon_bit(mon_r, n, RSR_MON_EN) &&
                   mon_bit(mon_r, n, RSR_MON_RST); // RQ5
      mon_irq[n] = supply_below[n] && !below_r[n] &&
                   mon_bit(mon_r, n, RSR_MON_EN) &&
                   !mon_bit(mon_r, n, RSR_MON_RST); // RQ5
    end
  end
  assign start = iwd_rst || wwd_rst || par_rst || ecc_rst || flt_rst ||
                 swreq_r || (|mon_rst);

  // Hold count for the request being started; longest wins
  always_comb begin
    hold_nxt = RSR_CNT_W'(RSR_WDOG_CYC); // RQ3 RQ4
    if (swreq_r || par_rst || ecc_rst || flt_rst) begin
      hold_nxt = RSR_CNT_W'(RSR_SW_CYC); // RQ11
    end
  end

  // Comparator edge history
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      below_r <= '0;
    end else if (clk_en) begin
      below_r <= supply_below;
    end
  end

  // Software reset request from the core, gated by internal_reset, or from a CTRL write
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      swreq_r <= 1'b0;
    end else if (clk_en) begin
      swreq_r <= system_reset_request_bit && !internal_reset ||
                 (wr && paddr == RSR_OFS_CTRL &&
                  pwdata[RSR_CTRL_SWREQ]); // RQ10
    end
  end

  // Reset timer: hold, then wait for supply recovery if a monitor fired
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= RSR_IDLE;
      cnt_r <= '0;
      mon_hold_r <= 1'b0;
      internal_reset <= 1'b0;
    end else if (clk_en) begin
      case (state_r)
        RSR_IDLE: begin
          if (start) begin
            state_r <= RSR_HOLD;
            cnt_r <= hold_nxt;
            mon_hold_r <= |mon_rst;
            internal_reset <= 1'b1;
          end
        end
        RSR_HOLD: begin
          if (|mon_rst) begin
            mon_hold_r <= 1'b1;
          end
          if (cnt_r > RSR_CNT_W'(1)) begin
            cnt_r <= cnt_r - RSR_CNT_W'(1); // RQ3 RQ4 RQ11
          end else if (mon_hold_r) begin
            state_r <= RSR_WAIT;
            cnt_r <= RSR_CNT_W'(RSR_MON_CYC);
          end else begin
            state_r <= RSR_IDLE;
            internal_reset <= 1'b0;
          end
        end
        RSR_WAIT: begin
          // Stabilization restarts while any supply is still low
          if (|supply_below) begin
            cnt_r <= RSR_CNT_W'(RSR_MON_CYC); // RQ7
          end else if (cnt_r > RSR_CNT_W'(1)) begin
            cnt_r <= cnt_r - RSR_CNT_W'(1);
          end else begin
            state_r <= RSR_IDLE;
            mon_hold_r <= 1'b0;
            internal_reset <= 1'b0; // RQ7
          end
        end
        default: begin
          state_r <= RSR_IDLE;
          internal_reset <= 1'b0;
        end
      endcase
    end
  end

  // Watchdog NMI and monitor interrupts
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      nmi_req <= 1'b0;
      supply_irq <= '0;
    end else if (clk_en) begin
      nmi_req <= (indep_watchdog_underflow && !cfg_r[RSR_CFG_IWD_RST]) ||
                 (windowed_watchdog_overflow &&
                  !cfg_r[RSR_CFG_WWD_RST]); // RQ1 RQ2
      supply_irq <= mon_irq; // RQ5
    end
  end

  // Status 0: power-on and monitor flags; only nrst initializes
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stat0_r <= 4'h1; // RQ18
    end else if (clk_en) begin
      if (!external_reset_pin_n) begin
        stat0_r[RSR_S0_POR] <= 1'b0; // RQ18
      end else if (wr && paddr == RSR_OFS_STAT0 && pwdata[RSR_S0_POR]) begin
        stat0_r[RSR_S0_POR] <= 1'b0;
      end
      for (int n = 0; n < 3; n++) begin
        if (mon_rst[n]) begin
          stat0_r[RSR_S0_MON0 + n] <= 1'b1; // RQ9 RQ20
        end else if (wr && paddr == RSR_OFS_STAT0 &&
                     pwdata[RSR_S0_MON0 + n]) begin
          stat0_r[RSR_S0_MON0 + n] <= 1'b0;
        end
      end
    end
  end

  // Status 1: cause flags, set wins over write-one-to-clear
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stat1_r <= '0;
    end else if (clk_en) begin
      for (int b = 0; b < 6; b++) begin
        if (wr && paddr == RSR_OFS_STAT1 && pwdata[b]) begin
          stat1_r[b] <= 1'b0;
        end
      end
      if (indep_watchdog_underflow) stat1_r[RSR_S1_IWD] <= 1'b1; // RQ1 RQ20
      if (windowed_watchdog_overflow) stat1_r[RSR_S1_WWD] <= 1'b1; // RQ2 RQ20
      if (swreq_r) stat1_r[RSR_S1_SW] <= 1'b1; // RQ19
      if (par_rst) stat1_r[RSR_S1_PAR] <= 1'b1; // RQ17
      if (ecc_rst) stat1_r[RSR_S1_ECC] <= 1'b1;
      if (flt_rst) stat1_r[RSR_S1_FLT] <= 1'b1; // RQ12
    end
  end

  // Cold/warm flag: only power-on clears, software may only set
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cws_r <= 1'b0; // RQ13
    end else if (clk_en) begin
      if (wr && paddr == RSR_OFS_STAT2 && pwdata[0]) begin
        cws_r <= 1'b1; // RQ14
      end
    end
  end

  // Config; monitors load only from the option word
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_r <= RSR_CFG_RST;
      mon_r <= '0; // RQ8
    end else if (clk_en) begin
      if (wr && paddr == RSR_OFS_CFG) begin
        cfg_r <= pwdata & RSR_CFG_RST;
      end
      if (wr && paddr == RSR_OFS_CTRL && pwdata[RSR_CTRL_LOAD]) begin
        mon_r <= option_setting_word; // RQ8
      end
    end
  end

  // Thresholds to the comparators, clamped to level 2
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      supply_monitor_level <= '0;
    end else if (clk_en) begin
      for (int n = 0; n < 3; n++) begin
        supply_monitor_level[2*n +: 2] <=
          (mon_r[n*RSR_MON_STRIDE + RSR_MON_LVL +: 2] > RSR_LVL_MAX) ?
          RSR_LVL_MAX : mon_r[n*RSR_MON_STRIDE + RSR_MON_LVL +: 2]; // RQ6
      end
    end
  end

  // Sticky SRAM error flags
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      err_r <= '0;
    end else if (clk_en) begin
      if (wr && paddr == RSR_OFS_ERR) begin
        err_r <= err_r & ~pwdata[2:0];
      end
      if (par_err) err_r[0] <= 1'b1;
      if (ecc_single) err_r[1] <= 1'b1;
      if (ecc_double) err_r[2] <= 1'b1;
    end
  end

  // Read mux
  always_comb begin
    rdata = '0;
    case (paddr)
      RSR_OFS_STAT0: rdata[3:0] = stat0_r;
      RSR_OFS_STAT1: rdata[5:0] = stat1_r;
      RSR_OFS_STAT2: rdata[0] = cws_r;
      RSR_OFS_CFG: rdata = cfg_r;
      RSR_OFS_MON: rdata[11:0] = mon_r;
      RSR_OFS_CTRL: rdata[1:0] = {1'b0, swreq_r};
      RSR_OFS_ERR: rdata[2:0] = err_r;
      default: rdata = '0;
    endcase
  end

  // APB slave: no wait state, data and ready registered
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && (paddr[1:0] != 2'h0 ||
                 paddr > RSR_OFS_ERR);
      if (rd) begin
        prdata <= rdata;
      end
    end
  end

  rsr_sram_check u_check (
    .core_clk(core_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .rd_par(sram_rd_par),
    .rd_data(sram_rd_data),
    .rd_par_bits(sram_rd_par_bits),
    .rd_ecc(sram_rd_ecc),
    .rd_chk(sram_rd_chk),
    .cor_data(sram_cor_data),
    .par_err(par_err),
    .ecc_single(ecc_single),
    .ecc_double(ecc_double)
  );
endmodule
`default_nettype wire

//--- inc/rsr_pkg.sv
/*
  Constants of the reset source recorder.
  Assumes one system clock at 200 MHz.
*/
`default_nettype none
package rsr_pkg;
  // APB register byte offsets
  localparam logic [7:0] RSR_OFS_STAT0 = 8'h00;
  localparam logic [7:0] RSR_OFS_STAT1 = 8'h04;
  localparam logic [7:0] RSR_OFS_STAT2 = 8'h08;
  localparam logic [7:0] RSR_OFS_CFG = 8'h0C;
  localparam logic [7:0] RSR_OFS_MON = 8'h10;
  localparam logic [7:0] RSR_OFS_CTRL = 8'h14;
  localparam logic [7:0] RSR_OFS_ERR = 8'h18;
  // Status 0 fields
  localparam int RSR_S0_POR = 0;
  localparam int RSR_S0_MON0 = 1;
  // Status 1 fields
  localparam int RSR_S1_IWD = 0;
  localparam int RSR_S1_WWD = 1;
  localparam int RSR_S1_SW = 2;
  localparam int RSR_S1_PAR = 3;
  localparam int RSR_S1_ECC = 4;
  localparam int RSR_S1_FLT = 5;
  // Config fields
  localparam int RSR_CFG_IWD_RST = 0;
  localparam int RSR_CFG_WWD_RST = 1;
  localparam int RSR_CFG_PAR_RST = 2;
  localparam int RSR_CFG_ECC_RST = 3;
  localparam logic [31:0] RSR_CFG_RST = 32'h0000_000F;
  // Monitor n: bit 4n enable, 4n+1 reset mode, 4n+3:4n+2 level
  localparam int RSR_MON_EN = 0;
  localparam int RSR_MON_RST = 1;
  localparam int RSR_MON_LVL = 2;
  localparam int RSR_MON_STRIDE = 4;
  localparam logic [1:0] RSR_LVL_MAX = 2'h2;
  localparam int RSR_CTRL_SWREQ = 0;
  localparam int RSR_CTRL_LOAD = 1;
  // Hold times in ns and derived counts
  localparam int RSR_CLK_MHZ = 200;
  localparam int RSR_T_WDOG_NS = 100;
  localparam int RSR_T_SW_NS = 200;
  localparam int RSR_T_MON_NS = 1000;
  localparam int RSR_WDOG_CYC = (RSR_T_WDOG_NS * RSR_CLK_MHZ + 999) / 1000;
  localparam int RSR_SW_CYC = (RSR_T_SW_NS * RSR_CLK_MHZ + 999) / 1000;
  localparam int RSR_MON_CYC = (RSR_T_MON_NS * RSR_CLK_MHZ + 999) / 1000;
  localparam int RSR_CNT_W = 10;
  // Reset timer states
  typedef enum logic [1:0] {
    RSR_IDLE = 2'b00,
    RSR_HOLD = 2'b01,
    RSR_WAIT = 2'b10
  } rsr_state_t;
endpackage
`default_nettype wire

//--- rtl/rsr_sram_check.sv
/*
  SRAM check: even parity per byte, or SEC-DED Hamming
  (32 data, 7 check bits) for the ECC area.
  Assumes read data and stored check bits arrive with a read strobe.
*/
`default_nettype none
module rsr_sram_check
  import rsr_pkg::*;
(
  input wire logic core_clk, // System clock
  input wire logic nrst, // Power-on reset, active low
  input wire logic clk_en, // Freezes state when low
  input wire logic rd_par, // Read strobe, parity area
  input wire logic [31:0] rd_data, // Read data word
  input wire logic [3:0] rd_par_bits, // Stored parity bits
  input wire logic rd_ecc, // Read strobe, ECC area
  input wire logic [6:0] rd_chk, // Stored check bits
  output logic [31:0] cor_data, // Corrected ECC data
  output logic par_err, // Parity error pulse
  output logic ecc_single, // Corrected single error pulse
  output logic ecc_double // Uncorrectable error pulse
);
  logic [38:0] cw;
  logic [5:0] syn;
  logic ovr;
  logic [3:0] par_bad;

  // Hamming layout, data at non-power positions
  function automatic logic [38:0] spread(input logic [31:0] d);
    logic [38:0] c;
    int k;
    c = '0;
    k = 0;
    for (int i = 1; i < 39; i++) begin
      if ((i & (i - 1)) != 0) begin
        c[i] = d[k];
        k++;
      end
    end
    return c;
  endfunction

  // Syndrome, overall parity and parity per byte
  always_comb begin
    cw = spread(rd_data);
    for (int b = 0; b < 6; b++) begin
      cw[1 << b] = rd_chk[b];
    end
    syn = '0;
    for (int i = 1; i < 39; i++) begin
      if (cw[i]) begin
        syn = syn ^ 6'(i);
      end
    end
    ovr = ^cw[38:1] ^ rd_chk[6];
    for (int b = 0; b < 4; b++) begin
      par_bad[b] = ^{rd_data[8*b +: 8], rd_par_bits[b]}; // RQ15
    end
  end

  // Registered results; a single error is flipped back in place
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cor_data <= '0;
      par_err <= 1'b0;
      ecc_single <= 1'b0;
      ecc_double <= 1'b0;
    end else if (clk_en) begin
      par_err <= rd_par && (par_bad != 4'h0); // RQ15
      ecc_single <= rd_ecc && ovr; // RQ16
      ecc_double <= rd_ecc && !ovr && (syn != 6'h00); // RQ16
      cor_data <= rd_data;
      if (rd_ecc && ovr) begin
        int k;
        k = 0;
        for (int i = 1; i < 39; i++) begin
          if ((i & (i - 1)) != 0) begin
            if (6'(i) == syn) begin
              cor_data[k] <= ~rd_data[k]; // RQ16
            end
            k++;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- bench/rsr_reset_recorder_checker.sv
/* Checker of reset timing, NMI and levels.
   Sees only the recorder's ports. */
`default_nettype none
module rsr_checker
  import rsr_pkg::*;
(
  input wire logic core_clk, // Clock
  input wire logic nrst, // Power-on reset
  input wire logic indep_watchdog_underflow, // Wd pulse
  input wire logic windowed_watchdog_overflow, // Wd pulse
  input wire logic [2:0] supply_below, // Comparators
  input wire logic [5:0] supply_monitor_level, // Levels
  input wire logic system_reset_request_bit, // Core request
  input wire logic [2:0] periph_fault, // Fault pulses
  input wire logic internal_reset, // Reset out
  input wire logic nmi_req // NMI pulse
);
  logic [9:0] hi_cnt_r;
  logic [7:0] quiet_r;
  logic [1:0] wd_h_r, src_r;
  logic [2:0] lg_h_r;
  logic ir_d_r, wd_any, lg_any;
  assign wd_any = indep_watchdog_underflow | windowed_watchdog_overflow;
  assign lg_any = system_reset_request_bit | (periph_fault != 3'h0);
  // Pulse length and quiet supply time
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hi_cnt_r <= 10'h0;
      quiet_r <= 8'hFF; // Supply good at power-on
    end else begin
      hi_cnt_r <= internal_reset ? hi_cnt_r + 10'h1 : 10'h0;
      if (supply_below != 3'h0)
        quiet_r <= 8'h00;
      else if (quiet_r != 8'hFF)
        quiet_r <= quiet_r + 8'h01;
    end
  end
  // Cause latched at the rise; history covers latency
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wd_h_r <= 2'h0;
      lg_h_r <= 3'h0;
      ir_d_r <= 1'b0;
      src_r <= 2'h0;
    end else begin
      wd_h_r <= {wd_h_r[0], wd_any};
      lg_h_r <= {lg_h_r[1:0], lg_any};
      ir_d_r <= internal_reset;
      if (internal_reset && !ir_d_r)
        src_r <= (wd_h_r != 2'h0) ? 2'h1 : (lg_h_r != 3'h0) ? 2'h2 : 2'h0;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_wd_req;
    wd_any && !internal_reset;
  endsequence
  sequence s_sw_req;
    system_reset_request_bit && !internal_reset;
  endsequence
  property p_wd_react;
    s_wd_req |-> ##[1:2] (internal_reset || nmi_req);
  endproperty
  a_wd_react: assert property (p_wd_react)
    else $error("watchdog ignored");
  property p_flt_react;
    periph_fault != 3'h0 && !internal_reset |-> ##[1:2] internal_reset;
  endproperty
  a_flt_react: assert property (p_flt_react)
    else $error("fault ignored");
  property p_sw_react;
    s_sw_req |-> ##[1:3] internal_reset;
  endproperty
  a_sw_react: assert property (p_sw_react)
    else $error("core request ignored");
  property p_wd_len;
    $fell(internal_reset) && src_r == 2'h1 |-> hi_cnt_r == 10'h014;
  endproperty
  a_wd_len: assert property (p_wd_len)
    else $error("watchdog hold wrong");
  property p_sw_len;
    $fell(internal_reset) && src_r == 2'h2 |-> hi_cnt_r == 10'h028;
  endproperty
  a_sw_len: assert property (p_sw_len)
    else $error("software hold wrong");
  property p_mon_hold;
    internal_reset && src_r == 2'h0 && supply_below != 3'h0
      |=> internal_reset;
  endproperty
  a_mon_hold: assert property (p_mon_hold)
    else $error("released while low");
  property p_mon_quiet;
    $fell(internal_reset) && src_r == 2'h0 |-> quiet_r >= 8'hC7;
  endproperty
  a_mon_quiet: assert property (p_mon_quiet)
    else $error("released too early");
  property p_nmi;
    nmi_req |-> wd_h_r != 2'h0 ##1 !nmi_req;
  endproperty
  a_nmi: assert property (p_nmi)
    else $error("stray or long nmi");
  property p_lvl;
    supply_monitor_level[1:0] != 2'h3 && supply_monitor_level[3:2] != 2'h3
      && supply_monitor_level[5:4] != 2'h3;
  endproperty
  a_lvl: assert property (p_lvl)
    else $error("level out of range");
endmodule
bind rsr_reset_recorder rsr_checker u_chk (
  .core_clk, .nrst, .indep_watchdog_underflow, .windowed_watchdog_overflow,
  .supply_below, .supply_monitor_level, .system_reset_request_bit,
  .periph_fault, .internal_reset, .nmi_req
);
`default_nettype wire

//--- bench/rsr_far_end.sv
/* Far side: watchdogs, comparators, core and fault detectors.
   Bench strobes select events; one clock domain. */
`default_nettype none
module rsr_far_end (
  input wire logic core_clk, // Clock
  input wire logic nrst, // Power-on reset
  input wire logic [3:0] kick, // Strobes: iwd, wwd, core, fault
  input wire logic [2:0] fault_sel, // Detectors that trip
  input wire logic [2:0] supply_low, // Supply state per monitor
  output logic indep_watchdog_underflow, // Underflow pulse
  output logic windowed_watchdog_overflow, // Overflow pulse
  output logic system_reset_request_bit, // Core request
  output logic [2:0] periph_fault, // Fault pulses
  output logic [2:0] supply_below // Comparator outputs
);
  // Events are one-cycle pulses; a held core bit would re-trigger
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      indep_watchdog_underflow <= 1'b0;
      windowed_watchdog_overflow <= 1'b0;
      system_reset_request_bit <= 1'b0;
      periph_fault <= 3'h0;
      supply_below <= 3'h0;
    end else begin
      indep_watchdog_underflow <= kick[0];
      windowed_watchdog_overflow <= kick[1];
      system_reset_request_bit <= kick[2];
      periph_fault <= kick[3] ? fault_sel : 3'h0;
      supply_below <= supply_low;
    end
  end
endmodule
`default_nettype wire

//--- bench/test_reset_source_recorder.sv
/* Bench: APB master, far-side model, expected-answer queue.
   Assumes the checker binds itself. */
`default_nettype none
module test_reset_source_recorder
  import rsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic RD = 1'b0;
  localparam logic WR = 1'b1;
  typedef struct packed {logic w; logic e; logic [31:0] d;} rsr_exp_t;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, sram_rd_data = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, internal_reset, nmi_req, sram_rd_par = 1'b0;
  logic external_reset_pin_n = 1'b1;
  logic indep_watchdog_underflow, windowed_watchdog_overflow;
  logic system_reset_request_bit;
  logic [2:0] periph_fault, supply_below, supply_irq;
  logic [2:0] supply_low = 3'h0, fault_sel = 3'h0;
  logic [3:0] kick = 4'h0, sram_rd_par_bits = 4'h0;
  logic [5:0] supply_monitor_level;
  logic [11:0] option_setting_word = 12'h0, o;
  logic [1:0] lv[3];
  int miscompares = 0, n_checks = 0, seed = 32'h8764, len, hits;
  rsr_exp_t exp_q[$];
  rsr_exp_t got;
  rsr_reset_recorder dut (
    .core_clk, .nrst, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .indep_watchdog_underflow,
    .windowed_watchdog_overflow, .supply_below, .supply_monitor_level,
    .option_setting_word, .system_reset_request_bit, .periph_fault,
    .external_reset_pin_n, .sram_rd_par, .sram_rd_ecc(1'b0),
    .sram_rd_data, .sram_rd_par_bits, .sram_rd_chk(7'h00),
    .sram_cor_data(), .internal_reset, .nmi_req, .supply_irq
  );
  rsr_far_end far (
    .core_clk, .nrst, .kick, .fault_sel, .supply_low,
    .indep_watchdog_underflow, .windowed_watchdog_overflow,
    .system_reset_request_bit, .periph_fault, .supply_below
  );
  always #2.5 core_clk = ~core_clk;
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic cmp_rd(input rsr_exp_t x);
    chk(pslverr === x.e && (x.w || x.e || prdata === x.d), "apb answer");
  endtask
  // Each completed transfer takes the oldest note
  always @(posedge core_clk) begin
    if (psel && penable && pready) begin
      got = exp_q.pop_front();
      cmp_rd(got);
    end
  end
  // One transfer after an idle edge
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d, input logic e = 1'b0);
    int n;
    @(posedge core_clk);
    exp_q.push_back({w, e, d});
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    chk(n < 16, "apb hang");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic fire(input int k);
    kick[k] <= 1'b1;
    @(posedge core_clk);
    kick <= 4'h0;
  endtask
  // Waits for the reset, counts its cycles
  task automatic hold_len();
    int n;
    n = 0;
    len = 0;
    while (internal_reset !== 1'b1 && n < 8) begin
      @(posedge core_clk);
      n++;
    end
    while (internal_reset === 1'b1 && len < 2000) begin
      @(posedge core_clk);
      len++;
    end
  endtask
  // Six cycles: one chosen pulse counts 1, any reset 2
  task automatic watch(input int sel);
    hits = 0;
    repeat (6) begin
      @(posedge core_clk);
      hits += int'((sel == 1 ? supply_irq[0] : nmi_req) === 1'b1);
      hits += 2 * int'(internal_reset !== 1'b0);
    end
  endtask
  task automatic par_rd(input logic [3:0] flip);
    logic [31:0] d;
    logic [3:0] p;
    d = $random(seed);
    for (int b = 0; b < 4; b++)
      p[b] = ^d[8*b +: 8];
    sram_rd_data <= d;
    sram_rd_par_bits <= p ^ flip;
    sram_rd_par <= 1'b1;
    @(posedge core_clk);
    sram_rd_par <= 1'b0;
  endtask
  task automatic end_sim();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Hang guard, well past a run of under 1000 cycles
  initial begin
    #60us;
    chk(1'b0, "timeout");
    end_sim();
  end
  initial begin
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    apb(RSR_OFS_STAT0, RD, 32'h1);
    apb(RSR_OFS_STAT2, RD, 32'h0);
    apb(RSR_OFS_CFG, RD, RSR_CFG_RST);
    apb(RSR_OFS_MON, RD, 32'h0);
    apb(8'h1C, RD, 32'h0, 1'b1);
    apb(8'h02, RD, 32'h0, 1'b1);
    apb(RSR_OFS_STAT2, WR, 32'h0);
    apb(RSR_OFS_STAT2, RD, 32'h0);
    apb(RSR_OFS_STAT2, WR, 32'h1);
    apb(RSR_OFS_STAT2, WR, 32'h0);
    apb(RSR_OFS_STAT2, RD, 32'h1);
    // Both watchdogs, reset then NMI mode
    for (int m = 0; m < 2; m++) begin
      for (int k = 0; k < 2; k++) begin
        fire(k);
        if (m == 0) begin
          hold_len();
          chk(len == RSR_WDOG_CYC, "watchdog hold");
        end else begin
          watch(0);
          chk(hits == 1, "nmi not reset");
        end
        apb(RSR_OFS_STAT1, RD, 32'h1 << k);
        apb(RSR_OFS_STAT1, WR, 32'h3F);
      end
      apb(RSR_OFS_CFG, WR, 32'hC);
    end
    apb(RSR_OFS_STAT2, RD, 32'h1);
    fire(2);
    hold_len();
    chk(len == RSR_SW_CYC, "software hold");
    apb(RSR_OFS_STAT1, RD, 32'h4);
    fault_sel <= 3'h1 << ($unsigned($random(seed)) % 3);
    fire(3);
    hold_len();
    chk(len == RSR_SW_CYC, "fault hold");
    apb(RSR_OFS_STAT1, RD, 32'h24);
    apb(RSR_OFS_STAT1, WR, 32'h3F);
    par_rd(4'h0);
    watch(2);
    chk(hits == 0, "good parity");
    par_rd(4'h1 << ($unsigned($random(seed)) % 4));
    hold_len();
    chk(len == RSR_SW_CYC, "parity reset");
    apb(RSR_OFS_STAT1, RD, 32'h8);
    apb(RSR_OFS_ERR, RD, 32'h1);
    // Monitor 0 interrupts, 1 and 2 reset
    for (int n = 0; n < 3; n++) begin
      lv[n] = 2'($unsigned($random(seed)) % 3);
      o[4*n +: 4] = {lv[n], n != 0, 1'b1};
    end
    option_setting_word <= o;
    apb(RSR_OFS_CTRL, WR, 32'h2);
    apb(RSR_OFS_MON, RD, {20'h0, o});
    chk(supply_monitor_level === {lv[2], lv[1], lv[0]}, "levels");
    for (int n = 0; n < 3; n++) begin
      supply_low[n] <= 1'b1;
      if (n == 0) begin
        watch(1);
        chk(hits == 1, "monitor irq");
      end else begin
        repeat (30) @(posedge core_clk);
        chk(internal_reset === 1'b1, "held while low");
      end
      supply_low[n] <= 1'b0;
      hold_len();
      chk(n == 0 ? len == 0 : len >= RSR_MON_CYC && len < 460, "release");
    end
    apb(RSR_OFS_STAT0, RD, 32'hD);
    external_reset_pin_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    external_reset_pin_n <= 1'b1;
    repeat (60) @(posedge core_clk);
    apb(RSR_OFS_STAT0, RD, 32'hC);
    apb(RSR_OFS_STAT2, RD, 32'h1);
    nrst <= 1'b0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    apb(RSR_OFS_STAT2, RD, 32'h0);
    apb(RSR_OFS_STAT0, RD, 32'h1);
    @(posedge core_clk);
    chk(exp_q.size() == 0, "answers missing");
    end_sim();
  end
endmodule
`default_nettype wire
